// *** strap_axi_regs.sv ***
// AXI4-Lite slave for the strap status and clock control registers
`timescale 1ns/1ns
module strap_axi_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [strap_config_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [strap_config_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [strap_config_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [strap_config_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [strap_config_pkg::DATA_W-1:0] statusWord,
  output logic clockGate
);

  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [strap_config_pkg::ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [strap_config_pkg::DATA_W-1:0] wData_q, wData_d, rdata_q, rdata_d;
  logic wLane_q, wLane_d, gate_q, gate_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  // ==========================================================================
  // Write and read channels
  // ==========================================================================
  always_comb begin
    awready = !awHeld_q && !bvalid_q;
    wready = !wHeld_q && !bvalid_q;
    arready = !rvalid_q;
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wLane_d = wLane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    gate_d = gate_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (awvalid && awready) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wLane_d = wstrb[0];
    end
    if (awHeld_q && wHeld_q) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = strap_config_pkg::RESP_OKAY;
      if (awAddr_q == strap_config_pkg::OFF_CLOCK_CTRL) begin
        if (wLane_q) begin
          gate_d = wData_q[strap_config_pkg::CLK_GATE_BIT];
        end
      end else if (awAddr_q != strap_config_pkg::OFF_STRAP_STATUS) begin
        bresp_d = strap_config_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = strap_config_pkg::RESP_OKAY;
      rdata_d = '0;
      if (araddr == strap_config_pkg::OFF_STRAP_STATUS) begin
        rdata_d = statusWord;
      end else if (araddr == strap_config_pkg::OFF_CLOCK_CTRL) begin
        rdata_d[strap_config_pkg::CLK_GATE_BIT] = gate_q;
      end else begin
        rresp_d = strap_config_pkg::RESP_SLVERR;
      end
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wLane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= strap_config_pkg::RESP_OKAY;
      gate_q <= strap_config_pkg::CTRL_RESET;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= strap_config_pkg::RESP_OKAY;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wLane_q <= wLane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      gate_q <= gate_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign clockGate = gate_q;

endmodule // strap_axi_regs

// *** strap_board_model.sv ***
// Board strap resistors and MAC-side clock sources facing the strap latch
`timescale 1ns/1ns
module strap_board_model (
  input wire logic [2:0] addrRes,
  input wire logic [3:0] modeRes,
  input wire logic clkEnRes,
  input wire logic styleRes,
  input wire logic [2:0] addrPinOut,
  input wire logic [2:0] addrPinOe,
  input wire logic [3:0] modePinOut,
  input wire logic [3:0] modePinOe,
  input wire logic clockEnablePinOut,
  input wire logic clockEnablePinOe,
  input wire logic ref_clock_out_pin,
  input wire logic ref_clock_out_pin_oe,
  output logic [2:0] addrStrapIn,
  output logic [3:0] modeStrapIn,
  output logic clockEnableStrapIn,
  output logic indicatorStrapIn,
  output logic ref125Clk,
  output logic txRefClk
);
  // ====================
  // Pin levels
  // ====================
  // Every strap pin has a fitted resistor, so a released pin settles to it
  assign addrStrapIn = (addrPinOe & addrPinOut) | (~addrPinOe & addrRes);
  assign modeStrapIn = (modePinOe & modePinOut) | (~modePinOe & modeRes);
  assign clockEnableStrapIn = clockEnablePinOe ? clockEnablePinOut : clkEnRes;
  assign indicatorStrapIn = ref_clock_out_pin_oe ? ref_clock_out_pin : styleRes;

  // ====================
  // Clock sources
  // ====================
  // Edges land on even times only, clear of the bench's odd sampling instants
  initial begin
    ref125Clk = 1'b0;
    forever #4 ref125Clk = ~ref125Clk;
  end

  initial begin
    txRefClk = 1'b0;
    forever #20 txRefClk = ~txRefClk;
  end
endmodule // strap_board_model

// *** strap_config_latch.sv ***
// Reset-time strap capture, mode decode and reference clock output control
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns

module strap_config_latch (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [strap_config_pkg::ADDR_STRAP_W-1:0] addrStrapIn,
  input wire logic [strap_config_pkg::MODE_W-1:0] modeStrapIn,
  input wire logic clockEnableStrapIn,
  input wire logic indicatorStrapIn,
  input wire logic ref125Clk,
  input wire logic txRefClk,
  input wire logic [strap_config_pkg::ADDR_STRAP_W-1:0] addrPinFunc,
  input wire logic [strap_config_pkg::MODE_W-1:0] modePinFunc,
  input wire logic clockEnablePinFunc,
  output logic [strap_config_pkg::ADDR_STRAP_W-1:0] addrPinOut,
  output logic [strap_config_pkg::ADDR_STRAP_W-1:0] addrPinOe,
  output logic [strap_config_pkg::ADDR_STRAP_W-1:0] addrPinPullUp,
  output logic [strap_config_pkg::MODE_W-1:0] modePinOut,
  output logic [strap_config_pkg::MODE_W-1:0] modePinOe,
  output logic [strap_config_pkg::MODE_W-1:0] modePinPullUp,
  output logic clockEnablePinOut,
  output logic clockEnablePinOe,
  output logic clockEnablePinPullUp,
  output logic ref_clock_out_pin,
  output logic ref_clock_out_pin_oe,
  output logic ref_clock_out_pin_pull_up,
  output logic txClkOut,
  output logic txClkOe,
  output logic [strap_config_pkg::STATION_W-1:0] station_address_strap,
  output logic [strap_config_pkg::MODE_W-1:0] modeStrap,
  output logic ref_clock_out_enable,
  output logic indicator_style_strap,
  output logic gmiiMiiMode,
  output logic nandTreeMode,
  output logic powerDownMode,
  output logic reservedMode,
  output logic configValid,
  input wire logic [strap_config_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [strap_config_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [strap_config_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [strap_config_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  strap_config_pkg::load_state_t state_q, state_d;
  logic [strap_config_pkg::STATION_W-1:0] station_q, station_d;
  logic [strap_config_pkg::MODE_W-1:0] mode_q, mode_d;
  logic clkEn_q, clkEn_d, style_q, style_d;
  logic gmii_q, gmii_d, nand_q, nand_d, down_q, down_d, resv_q, resv_d;
  strap_config_pkg::mode_class_t modeClass;
  logic inReset;
  logic clockGate;
  logic [strap_config_pkg::DATA_W-1:0] statusWord;

  // ==========================================================================
  // Capture sequencer
  // ==========================================================================
  // The async reset only clears; the pin levels are taken by the second clocked
  // edge after release so no flop ever loads a port under reset.
  always_comb begin
    state_d = state_q;
    station_d = station_q;
    mode_d = mode_q;
    clkEn_d = clkEn_q;
    style_d = style_q;
    modeClass = strap_config_pkg::decode_mode(modeStrapIn);
    gmii_d = gmii_q;
    nand_d = nand_q;
    down_d = down_q;
    resv_d = resv_q;
    case (state_q)
      strap_config_pkg::LOAD_IDLE: begin
        state_d = strap_config_pkg::LOAD_CAPTURE;
      end
      strap_config_pkg::LOAD_CAPTURE: begin
        station_d = {strap_config_pkg::ADDR_HIGH_BITS, addrStrapIn};
        mode_d = modeStrapIn;
        clkEn_d = clockEnableStrapIn;
        style_d = indicatorStrapIn;
        gmii_d = (modeClass == strap_config_pkg::CLASS_GMII_MII);
        nand_d = (modeClass == strap_config_pkg::CLASS_NAND_TREE);
        down_d = (modeClass == strap_config_pkg::CLASS_POWER_DOWN);
        resv_d = (modeClass == strap_config_pkg::CLASS_RESERVED);
        state_d = strap_config_pkg::LOAD_DONE;
      end
      strap_config_pkg::LOAD_DONE: begin
        state_d = strap_config_pkg::LOAD_DONE;
      end
      default: begin
        state_d = strap_config_pkg::LOAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= strap_config_pkg::LOAD_IDLE;
      station_q <= '0;
      mode_q <= '0;
      clkEn_q <= 1'b0;
      style_q <= 1'b0;
      gmii_q <= 1'b0;
      nand_q <= 1'b0;
      down_q <= 1'b0;
      resv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      station_q <= station_d;
      mode_q <= mode_d;
      clkEn_q <= clkEn_d;
      style_q <= style_d;
      gmii_q <= gmii_d;
      nand_q <= nand_d;
      down_q <= down_d;
      resv_q <= resv_d;
    end
  end

  // Pins stay in strap mode until capture is complete, so the level sampled
  // is never our own drive.
  assign inReset = (state_q != strap_config_pkg::LOAD_DONE);

  // ==========================================================================
  // Shared pin cells
  // ==========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < strap_config_pkg::ADDR_STRAP_W; gi++) begin : gAddrPin
      strap_pin_cell uAddr (
        .inReset(inReset),
        .funcOut(addrPinFunc[gi]),
        .funcEnable(1'b1),
        .padOut(addrPinOut[gi]),
        .padOe(addrPinOe[gi]),
        .pullUpOn(addrPinPullUp[gi])
      );
    end
    for (gi = 0; gi < strap_config_pkg::MODE_W; gi++) begin : gModePin
      strap_pin_cell uMode (
        .inReset(inReset),
        .funcOut(modePinFunc[gi]),
        .funcEnable(1'b1),
        .padOut(modePinOut[gi]),
        .padOe(modePinOe[gi]),
        .pullUpOn(modePinPullUp[gi])
      );
    end
  endgenerate

  strap_pin_cell uClkEnPin (
    .inReset(inReset),
    .funcOut(clockEnablePinFunc),
    .funcEnable(1'b1),
    .padOut(clockEnablePinOut),
    .padOe(clockEnablePinOe),
    .pullUpOn(clockEnablePinPullUp)
  );

  // Clock output only drives when enabled by strap and software; a disabled
  // output is released rather than held low.
  strap_pin_cell uRefClkPin (
    .inReset(inReset),
    .funcOut(ref125Clk),
    .funcEnable(clkEn_q && clockGate && !down_q),
    .padOut(ref_clock_out_pin),
    .padOe(ref_clock_out_pin_oe),
    .pullUpOn(ref_clock_out_pin_pull_up)
  );

  always_comb begin
    txClkOut = gmii_q ? txRefClk : 1'b0;
    txClkOe = gmii_q;
  end

  // ==========================================================================
  // Register bus
  // ==========================================================================
  always_comb begin
    statusWord = '0;
    statusWord[strap_config_pkg::ADDR_LSB +: strap_config_pkg::STATION_W] = station_q;
    statusWord[strap_config_pkg::MODE_LSB +: strap_config_pkg::MODE_W] = mode_q;
    statusWord[strap_config_pkg::CLKEN_BIT] = clkEn_q;
    statusWord[strap_config_pkg::STYLE_BIT] = style_q;
    statusWord[strap_config_pkg::MODE_CLASS_LSB +: 4] = {resv_q, down_q, nand_q, gmii_q};
  end

  strap_axi_regs uRegs (
    .clk(clk),
    .rst_b(rst_b),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .statusWord(statusWord),
    .clockGate(clockGate)
  );

  assign station_address_strap = station_q;
  assign modeStrap = mode_q;
  assign ref_clock_out_enable = clkEn_q;
  assign indicator_style_strap = style_q;
  assign gmiiMiiMode = gmii_q;
  assign nandTreeMode = nand_q;
  assign powerDownMode = down_q;
  assign reservedMode = resv_q;
  assign configValid = !inReset;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence capture_seq;
    state_q == strap_config_pkg::LOAD_CAPTURE;
  endsequence

  sequence done_seq;
    state_q == strap_config_pkg::LOAD_DONE;
  endsequence

  chk_address_upper_zero: assert property (
    @(posedge clk) disable iff (!rst_b) station_address_strap[4:3] == 2'h0)
    else $error("Station address upper bits not zero");

  chk_address_low_capture: assert property (
    @(posedge clk) disable iff (!rst_b)
    capture_seq |=> station_address_strap[2:0] == $past(addrStrapIn))
    else $error("Station address low bits not captured");

  chk_mode_capture: assert property (
    @(posedge clk) disable iff (!rst_b)
    capture_seq |=> modeStrap == $past(modeStrapIn) &&
      gmiiMiiMode == ($past(modeStrapIn) == strap_config_pkg::MODE_GMII))
    else $error("Mode strap not captured or decoded");

  chk_latch_frozen: assert property (
    @(posedge clk) disable iff (!rst_b)
    done_seq |=> $stable(station_address_strap) && $stable(modeStrap) &&
      $stable(indicator_style_strap) && $stable(ref_clock_out_enable))
    else $error("Latched strap changed after capture");

  // The release edge itself still clears the sequencer, so the count starts
  // at the first edge that samples reset high.
  chk_capture_timing: assert property (
    @(posedge clk) disable iff (!rst_b)
    rst_b && state_q == strap_config_pkg::LOAD_IDLE |=> capture_seq ##1 done_seq)
    else $error("Capture did not finish two edges after release");

  chk_pins_in_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    !configValid |-> addrPinOe == '0 && modePinOe == '0 && !ref_clock_out_pin_oe &&
      modePinPullUp == '1)
    else $error("Strap pin driven during capture");

  chk_refclk_disabled: assert property (
    @(posedge clk) disable iff (!rst_b)
    !ref_clock_out_enable |-> !ref_clock_out_pin_oe)
    else $error("Reference clock driven while strap disabled");

  chk_style_capture: assert property (
    @(posedge clk) disable iff (!rst_b)
    capture_seq |=> indicator_style_strap == $past(indicatorStrapIn))
    else $error("Indicator style not captured");

  chk_mode_classes: assert property (
    @(posedge clk) disable iff (!rst_b)
    done_seq |-> nandTreeMode == (modeStrap == strap_config_pkg::MODE_NAND) &&
      powerDownMode == (modeStrap == strap_config_pkg::MODE_POWER_DOWN))
    else $error("Test or power-down mode decode wrong");

  chk_tx_clock_dir: assert property (
    @(posedge clk) disable iff (!rst_b)
    txClkOe == (modeStrap == strap_config_pkg::MODE_GMII) && (txClkOe || !txClkOut))
    else $error("Transmit clock direction wrong");

endmodule // strap_config_latch

// *** strap_config_latch_tb.sv ***
// Self-checking bench for the strap configuration latch
`timescale 1ns/1ns
module strap_config_latch_tb;
  logic clk, rst_b, clkEnRes, styleRes, clockEnableStrapIn, indicatorStrapIn, ref125Clk;
  logic [2:0] addrRes, addrStrapIn, addrPinFunc, addrPinOut, addrPinOe, addrPinPullUp;
  logic [3:0] modeRes, modeStrapIn, modePinFunc, modePinOut, modePinOe, modePinPullUp;
  logic [3:0] modeStrap, wstrb;
  logic txRefClk, clockEnablePinFunc, clockEnablePinOut, clockEnablePinOe, clockEnablePinPullUp;
  logic ref_clock_out_pin, ref_clock_out_pin_oe, ref_clock_out_pin_pull_up, txClkOut, txClkOe;
  logic [4:0] station_address_strap;
  logic ref_clock_out_enable, indicator_style_strap, gmiiMiiMode, nandTreeMode, powerDownMode;
  logic reservedMode, configValid, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cfgSeen;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [16:0] cfgVec;
  logic [35:0] expQ[$];
  int fails, samplesChecked, seed;

  strap_config_latch dut (.*);
  strap_board_model board (.*);

  assign cfgVec = {txClkOe, ref_clock_out_pin_oe, reservedMode, powerDownMode, nandTreeMode,
    gmiiMiiMode, indicator_style_strap, ref_clock_out_enable, modeStrap, station_address_strap};

  // ====================
  // Reporting
  // ====================
  task results();
    if (fails == 0 && samplesChecked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [35:0] got, input logic [35:0] want);
    samplesChecked++;
    if (got !== want) begin
      fails++;
      $display("BAD t=%0t got %h expected %h", $time, got, want);
    end
  endtask

  // ====================
  // Bus master
  // ====================
  // Ready is sampled mid-cycle; inputs only move after rising edges, so it holds to the edge
  task axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r, input logic [31:0] e);
    logic pa, pw, pb, ta, tw, tb;
    int n;
    pa = 1'b1;
    pw = wr;
    pb = 1'b1;
    n = 0;
    expQ.push_back({wr ? 2'd2 : 2'd1, r, wr ? 32'h0 : e});
    @(posedge clk);
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while ((pa || pw || pb) && n < 40) begin
      @(negedge clk);
      ta = pa && (wr ? awready : arready);
      tw = pw && wready;
      tb = pb && (wr ? bvalid : rvalid);
      @(posedge clk);
      if (ta && wr) awvalid <= 1'b0;
      if (ta && !wr) arvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb && wr) bready <= 1'b0;
      if (tb && !wr) rready <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
      pb = pb && !tb;
      n++;
    end
    if (pa || pw || pb) begin
      fails++;
      results();
    end
  endtask

  // ====================
  // Result monitor
  // ====================
  always @(negedge clk) begin
    logic [35:0] got;
    logic [35:0] want;
    logic hit;
    hit = 1'b1;
    got = 36'h0;
    if (rvalid && rready) got = {2'd1, rresp, rdata};
    else if (bvalid && bready) got = {2'd2, bresp, 32'h0};
    else if (configValid && !cfgSeen) got = {2'd3, 17'h0, cfgVec};
    else hit = 1'b0;
    cfgSeen <= configValid;
    if (hit && expQ.size() == 0) begin
      fails++;
      $display("BAD t=%0t unexpected result %h", $time, got);
    end else if (hit) begin
      want = expQ.pop_front();
      chk(got, want);
    end
  end

  // ====================
  // Stimulus
  // ====================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    logic [2:0] a;
    logic ce, st, gm, nd, pd, rs;
    logic [16:0] cfg;
    logic [31:0] word;
    seed = 52;
    fails = 0;
    samplesChecked = 0;
    rst_b = 1'b0;
    {addrRes, modeRes, clkEnRes, styleRes, addrPinFunc, modePinFunc, clockEnablePinFunc} = 17'h0;
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = 57'h0;
    repeat (8) @(posedge clk);
    for (int m = 0; m < 16; m++) begin
      a = 3'($random(seed));
      ce = 1'($random(seed));
      st = 1'($random(seed));
      gm = (m == 1);
      nd = (m == 4);
      pd = (m == 7);
      rs = !(gm || nd || pd);
      @(posedge clk);
      rst_b <= 1'b0;
      addrRes <= a;
      modeRes <= 4'(m);
      clkEnRes <= ce;
      styleRes <= st;
      addrPinFunc <= 3'($random(seed));
      modePinFunc <= 4'($random(seed));
      clockEnablePinFunc <= 1'($random(seed));
      repeat (2) @(posedge clk);
      #2;
      chk(36'({configValid, cfgVec, addrPinOe, modePinOe}), 36'h0);
      chk(36'({addrPinPullUp, modePinPullUp, ref_clock_out_pin_pull_up}), 36'hff);
      cfg = {gm, ce && !pd, rs, pd, nd, gm, st, ce, 4'(m), 2'b00, a};
      expQ.push_back({2'd3, 17'h0, cfg});
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      #2;
      chk(36'({addrPinOe, modePinOe, clockEnablePinOe, addrPinPullUp, modePinPullUp,
        clockEnablePinPullUp, addrPinOut, modePinOut, clockEnablePinOut}),
        36'({16'hff00, addrPinFunc, modePinFunc, clockEnablePinFunc}));
      if (ce && !pd) chk(36'(ref_clock_out_pin), 36'(ref125Clk));
      if (gm) chk(36'(txClkOut), 36'(txRefClk));
      @(posedge clk);
      addrRes <= ~a;
      modeRes <= ~4'(m);
      clkEnRes <= ~ce;
      styleRes <= ~st;
      addrPinFunc <= ~addrPinFunc;
      modePinFunc <= ~modePinFunc;
      clockEnablePinFunc <= ~clockEnablePinFunc;
      repeat (3) @(posedge clk);
      #2;
      chk(36'(cfgVec), 36'(cfg));
      word = 32'(a) | (32'(m) << strap_config_pkg::MODE_LSB);
      word = word | (32'(ce) << strap_config_pkg::CLKEN_BIT);
      word = word | (32'(st) << strap_config_pkg::STYLE_BIT);
      word = word | (32'({rs, pd, nd, gm}) << strap_config_pkg::MODE_CLASS_LSB);
      axi(1'b0, strap_config_pkg::OFF_STRAP_STATUS, 32'h0, 4'h0, 2'h0, word);
      axi(1'b1, strap_config_pkg::OFF_STRAP_STATUS, 32'h0, 4'hf, 2'h0, 32'h0);
      axi(1'b1, 8'h08, 32'h0, 4'hf, strap_config_pkg::RESP_SLVERR, 32'h0);
      axi(1'b0, 8'h0c, 32'h0, 4'h0, strap_config_pkg::RESP_SLVERR, 32'h0);
      axi(1'b1, strap_config_pkg::OFF_CLOCK_CTRL, 32'h0, 4'he, 2'h0, 32'h0);
      axi(1'b0, strap_config_pkg::OFF_CLOCK_CTRL, 32'h0, 4'h0, 2'h0, 32'h1);
      axi(1'b1, strap_config_pkg::OFF_CLOCK_CTRL, 32'h0, 4'h1, 2'h0, 32'h0);
      axi(1'b0, strap_config_pkg::OFF_CLOCK_CTRL, 32'h0, 4'h0, 2'h0, 32'h0);
      @(posedge clk);
      #2;
      chk(36'(ref_clock_out_pin_oe), 36'h0);
      axi(1'b0, strap_config_pkg::OFF_STRAP_STATUS, 32'h0, 4'h0, 2'h0, word);
    end
    repeat (4) @(posedge clk);
    if (expQ.size() != 0) fails++;
    results();
  end
endmodule // strap_config_latch_tb

// *** strap_config_pkg.sv ***
// Shared constants and types for the strap configuration latch
package strap_config_pkg;

  // ==========================================================================
  // Bus and register map
  // ==========================================================================
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_STRAP_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CLOCK_CTRL = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Field layout of the status and clock control registers
  // ==========================================================================
  localparam int ADDR_LSB = 0;
  localparam int MODE_LSB = 8;
  localparam int CLKEN_BIT = 12;
  localparam int STYLE_BIT = 13;
  localparam int MODE_CLASS_LSB = 16;
  localparam int CLK_GATE_BIT = 0;

  // ==========================================================================
  // Straps and modes
  // ==========================================================================
  localparam int STATION_W = 5;
  localparam int ADDR_STRAP_W = 3;
  localparam int MODE_W = 4;
  localparam logic [1:0] ADDR_HIGH_BITS = 2'h0;
  localparam logic [MODE_W-1:0] MODE_GMII = 4'h1;
  localparam logic [MODE_W-1:0] MODE_NAND = 4'h4;
  localparam logic [MODE_W-1:0] MODE_POWER_DOWN = 4'h7;
  localparam logic CTRL_RESET = 1'h1;

  typedef enum logic [1:0] {
    CLASS_RESERVED,
    CLASS_GMII_MII,
    CLASS_NAND_TREE,
    CLASS_POWER_DOWN
  } mode_class_t;

  typedef enum logic [1:0] {
    LOAD_IDLE,
    LOAD_CAPTURE,
    LOAD_DONE
  } load_state_t;

  // ==========================================================================
  // Clock figures
  // ==========================================================================
  localparam int CLK_HZ = 20_000_000;
  localparam int REF_OUT_MHZ = 125;
  localparam int REF_IN_MHZ = 25;

  function automatic mode_class_t decode_mode(input logic [MODE_W-1:0] code);
    case (code)
      MODE_GMII: decode_mode = CLASS_GMII_MII;
      MODE_NAND: decode_mode = CLASS_NAND_TREE;
      MODE_POWER_DOWN: decode_mode = CLASS_POWER_DOWN;
      default: decode_mode = CLASS_RESERVED;
    endcase
  endfunction

endpackage

// *** strap_pin_cell.sv ***
// One shared strap pin: input with pull-up during reset, output afterwards while funcEnable is high
`timescale 1ns/1ns
module strap_pin_cell (
  input wire logic inReset,
  input wire logic funcOut,
  input wire logic funcEnable,
  output logic padOut,
  output logic padOe,
  output logic pullUpOn
);

  // ==========================================================================
  // Direction control
  // ==========================================================================
  always_comb begin
    pullUpOn = inReset;
    padOe = !inReset && funcEnable;
    padOut = inReset ? 1'b0 : funcOut;
  end

endmodule // strap_pin_cell
